// ==== design/clu_defs.vh ====
// register map, field positions and reset values of the custom logic unit
// assumes a 32-bit classic wishbone slave with word-aligned byte addresses
`ifndef CLU_DEFS_VH
`define CLU_DEFS_VH
`define CLU_ADR_CTRL 6'h00
`define CLU_ADR_SEQ 6'h08
`define CLU_ADR_STAT 6'h0C
`define CLU_ADR_LUT0 6'h10
`define CLU_ADR_LUT1 6'h14
`define CLU_ADR_LUT2 6'h18
`define CLU_ADR_LUT3 6'h1C
`define CLU_CTRL_SWRST 0
`define CLU_CTRL_ENABLE 1
`define CLU_CTRL_TCALT 2
`define CLU_LUT_ENABLE 1
`define CLU_LUT_SEL_LO 4
`define CLU_LUT_SEL_HI 7
`define CLU_LUT_TRUTH_LO 8
`define CLU_LUT_TRUTH_HI 15
`define CLU_LUT_W 16
`define CLU_SEQ_W 4
`define CLU_SEQ_NONE 2'h0
`define CLU_SEQ_DFF 2'h1
`define CLU_SEQ_JK 2'h2
`define CLU_SEQ_RS 2'h3
`define CLU_SEL_TC 4'h8
`define CLU_ZERO32 32'h00000000
`define CLU_CTRL_RST 3'h0
`define CLU_SEQ_RST 4'h0
`define CLU_LUT_RST 16'h0000
`define CLU_HELD_ALL 4'hF
`define CLU_Q_RST 2'h0
`define CLU_OUT_RST 4'h0
`define CLU_PIN_RST 12'h000
`define CLU_TMR_RST 5'h00
`endif

// ==== design/clu_top.v ====
// custom logic unit: four lookup tables, two sequential elements, wishbone slave
// assumes clk_i is the peripheral clock and table inputs arrive from pins/timers
// outside inputs reach the tables only through two-flop synchronisers
`timescale 1ns/1ps
`include "clu_defs.vh"

module clu_top (
  input wire clk_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [5:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output wire wb_ack_o,
  input wire [11:0] pin_in_i,
  input wire [4:0] timer_in_i,
  output reg [3:0] lut_out_o,
  output reg prot_err_o
);
  reg [2:0] ctrl; // soft reset unused, enable, timer alternate
  reg [`CLU_SEQ_W-1:0] seq;
  reg [`CLU_LUT_W-1:0] lut0;
  reg [`CLU_LUT_W-1:0] lut1;
  reg [`CLU_LUT_W-1:0] lut2;
  reg [`CLU_LUT_W-1:0] lut3;
  reg [3:0] held; // per-table sequential reset hold
  reg [1:0] q; // sequential element state, pair 0 and pair 1
  reg ack;
  reg [11:0] pin_s1;
  reg [11:0] pin_s2;
  reg [4:0] tmr_s1;
  reg [4:0] tmr_s2;
  reg [3:0] next_held;
  reg [3:0] tin;
  reg [3:0] lut_raw;
  reg [3:0] next_lut_out;
  reg [31:0] next_rdata;

  // address match for one register of the map
  function adr_hit;
    input [5:0] adr;
    input [5:0] reg_adr;
    begin
      adr_hit = (adr == reg_adr);
    end
  endfunction

  // a request is taken once, on the edge before ack rises
  wire acc = wb_cyc_i & wb_stb_i & ~ack;
  wire wr = acc & wb_we_i & wb_sel_i[0];
  // global and per-table enables
  wire glob_en = ctrl[`CLU_CTRL_ENABLE];
  wire [3:0] en = {lut3[`CLU_LUT_ENABLE], lut2[`CLU_LUT_ENABLE],
                   lut1[`CLU_LUT_ENABLE], lut0[`CLU_LUT_ENABLE]};
  wire wr_ctrl = wr & adr_hit(wb_adr_i, `CLU_ADR_CTRL);
  // configuration writes pass only while the unit is globally off
  wire wr_open = wr & ~glob_en;
  wire wr_seq = wr_open & adr_hit(wb_adr_i, `CLU_ADR_SEQ);
  wire wr_lut0 = wr_open & adr_hit(wb_adr_i, `CLU_ADR_LUT0);
  wire wr_lut1 = wr_open & adr_hit(wb_adr_i, `CLU_ADR_LUT1);
  wire wr_lut2 = wr_open & adr_hit(wb_adr_i, `CLU_ADR_LUT2);
  wire wr_lut3 = wr_open & adr_hit(wb_adr_i, `CLU_ADR_LUT3);

  // rewriting the global enable while already on frees re-enabled tables
  wire rearm = wr_ctrl & wb_dat_i[`CLU_CTRL_ENABLE] & glob_en;

  // table evaluation: three selected inputs index the truth table
  // a disabled table always evaluates to zero
  function lut_eval;
    input [`CLU_LUT_W-1:0] cfg;
    input [2:0] ins;
    reg [7:0] truth;
    begin
      truth = cfg[`CLU_LUT_TRUTH_HI:`CLU_LUT_TRUTH_LO];
      lut_eval = cfg[`CLU_LUT_ENABLE] & truth[ins];
    end
  endfunction

  // gather three pin inputs, or the timer input when selected
  // only input 0 of a table can be replaced by its timer
  function [2:0] lut_ins;
    input [`CLU_LUT_W-1:0] cfg;
    input [2:0] pins;
    input t;
    begin
      if (cfg[`CLU_LUT_SEL_HI:`CLU_LUT_SEL_LO] == `CLU_SEL_TC)
        lut_ins = {pins[2:1], t};
      else
        lut_ins = pins;
    end
  endfunction

  // two-stage synchroniser for the pin inputs
  always @(posedge clk_i) begin
    if (rst_i) begin
      pin_s1 <= `CLU_PIN_RST;
      pin_s2 <= `CLU_PIN_RST;
    end else begin
      pin_s1 <= pin_in_i;
      pin_s2 <= pin_s1;
    end
  end

  // two-stage synchroniser for the timer inputs
  always @(posedge clk_i) begin
    if (rst_i) begin
      tmr_s1 <= `CLU_TMR_RST;
      tmr_s2 <= `CLU_TMR_RST;
    end else begin
      tmr_s1 <= timer_in_i;
      tmr_s2 <= tmr_s1;
    end
  end

  // timer routing per selection
  // the default routing is shifted by one instance on this silicon
  always @* begin
    if (ctrl[`CLU_CTRL_TCALT])
      tin = tmr_s2[3:0];
    else
      tin = {tmr_s2[2], tmr_s2[1], tmr_s2[0], tmr_s2[4]};
  end

  // combinational table outputs
  // each table takes three synchronised pins, bits 3n+2..3n
  always @* begin
    lut_raw[0] = lut_eval(lut0, lut_ins(lut0, pin_s2[2:0], tin[0]));
    lut_raw[1] = lut_eval(lut1, lut_ins(lut1, pin_s2[5:3], tin[1]));
    lut_raw[2] = lut_eval(lut2, lut_ins(lut2, pin_s2[8:6], tin[2]));
    lut_raw[3] = lut_eval(lut3, lut_ins(lut3, pin_s2[11:9], tin[3]));
  end

  // hold sets while a table is off and stays set until the global enable
  // is rewritten with the table back on
  always @* begin
    next_held = held | ~en;
    if (rearm)
      next_held = next_held & ~en;
  end

  // per-table hold; set from reset so no element runs before configuration
  always @(posedge clk_i) begin
    if (rst_i)
      held <= `CLU_HELD_ALL;
    else
      held <= next_held;
  end

  // global control; the soft reset bit is a strobe and is never stored
  always @(posedge clk_i) begin
    if (rst_i)
      ctrl <= `CLU_CTRL_RST;
    else if (wr_ctrl)
      ctrl <= {wb_dat_i[`CLU_CTRL_TCALT], wb_dat_i[`CLU_CTRL_ENABLE], 1'b0};
  end

  // sequencer modes, writable only while the unit is off
  always @(posedge clk_i) begin
    if (rst_i)
      seq <= `CLU_SEQ_RST;
    else if (wr_seq)
      seq <= wb_dat_i[`CLU_SEQ_W-1:0];
  end

  // table 0 control, locked by the global enable
  always @(posedge clk_i) begin
    if (rst_i)
      lut0 <= `CLU_LUT_RST;
    else if (wr_lut0)
      lut0 <= wb_dat_i[`CLU_LUT_W-1:0];
  end

  // table 1 control, locked by the global enable
  always @(posedge clk_i) begin
    if (rst_i)
      lut1 <= `CLU_LUT_RST;
    else if (wr_lut1)
      lut1 <= wb_dat_i[`CLU_LUT_W-1:0];
  end

  // table 2 control, locked by the global enable
  always @(posedge clk_i) begin
    if (rst_i)
      lut2 <= `CLU_LUT_RST;
    else if (wr_lut2)
      lut2 <= wb_dat_i[`CLU_LUT_W-1:0];
  end

  // table 3 control, locked by the global enable
  always @(posedge clk_i) begin
    if (rst_i)
      lut3 <= `CLU_LUT_RST;
    else if (wr_lut3)
      lut3 <= wb_dat_i[`CLU_LUT_W-1:0];
  end

  // protection error pulse on soft reset write
  // it rises for a soft reset request even though nothing is reset
  always @(posedge clk_i) begin
    if (rst_i)
      prot_err_o <= 1'b0;
    else
      prot_err_o <= wr_ctrl & wb_dat_i[`CLU_CTRL_SWRST];
  end

  // an element is cleared while its table is held or the unit is off
  wire clr0 = held[0] | ~glob_en;
  wire clr1 = held[2] | ~glob_en;

  // sequencer mode of each element
  wire [1:0] mode0 = seq[1:0];
  wire [1:0] mode1 = seq[3:2];

  // next state of one sequential element
  function seq_next;
    input [1:0] mode;
    input cur;
    input a;
    input b;
    begin
      case (mode)
        `CLU_SEQ_DFF: seq_next = a;
        `CLU_SEQ_JK: seq_next = (a & ~cur) | (~b & cur);
        `CLU_SEQ_RS: seq_next = a | cur; // reset input ignored
        default: seq_next = cur;
      endcase
    end
  endfunction

  // sequential elements; each pair uses even table as data/set, odd as clear in JK mode (RS mode ignores the odd table)
  always @(posedge clk_i) begin
    if (rst_i) begin
      q <= `CLU_Q_RST;
    end else begin
      if (clr0)
        q[0] <= 1'b0;
      else
        q[0] <= seq_next(mode0, q[0], lut_raw[0], lut_raw[1]);
      if (clr1)
        q[1] <= 1'b0;
      else
        q[1] <= seq_next(mode1, q[1], lut_raw[2], lut_raw[3]);
    end
  end

  // even tables show their element once a sequencer mode is chosen
  always @* begin
    // nothing leaves the unit while it is globally off
    next_lut_out[0] = ((mode0 == `CLU_SEQ_NONE) ? lut_raw[0] : q[0]) & glob_en;
    next_lut_out[1] = lut_raw[1] & glob_en;
    next_lut_out[2] = ((mode1 == `CLU_SEQ_NONE) ? lut_raw[2] : q[1]) & glob_en;
    next_lut_out[3] = lut_raw[3] & glob_en;
  end

  // registered table outputs
  always @(posedge clk_i) begin
    if (rst_i)
      lut_out_o <= `CLU_OUT_RST;
    else
      lut_out_o <= next_lut_out;
  end

  // read data for the addressed register; zero outside a read
  always @* begin
    next_rdata = `CLU_ZERO32;
    if (acc & ~wb_we_i) begin
      case (wb_adr_i)
        `CLU_ADR_CTRL: next_rdata = {29'h0, ctrl};
        `CLU_ADR_SEQ: next_rdata = {28'h0, seq};
        `CLU_ADR_STAT: next_rdata = {26'h0, q, held};
        `CLU_ADR_LUT0: next_rdata = {16'h0, lut0};
        `CLU_ADR_LUT1: next_rdata = {16'h0, lut1};
        `CLU_ADR_LUT2: next_rdata = {16'h0, lut2};
        `CLU_ADR_LUT3: next_rdata = {16'h0, lut3};
        default: next_rdata = `CLU_ZERO32;
      endcase
    end
  end

  // single-cycle ack; read data stands only in the ack cycle
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack <= 1'b0;
      wb_dat_o <= `CLU_ZERO32;
    end else begin
      // ack falls the cycle after it rose because acc masks it
      ack <= acc;
      wb_dat_o <= next_rdata;
    end
  end
  assign wb_ack_o = ack;
endmodule

// ==== tb/clu_asserts.sv ====
// port checker for the custom logic unit
// assumes bind to clu_top, one clock, sync reset
`timescale 1ns/1ps
module clu_asserts (
  input wire clk_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [5:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  input wire [3:0] lut_out_o,
  input wire prot_err_o
);
  // request taken, and a taken soft reset write
  wire req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire srst = req && wb_we_i && wb_adr_i == 6'h00 && wb_sel_i[0] && wb_dat_i[0];
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ack_answer_a: assert property (req |=> wb_ack_o)
    else $error("request not acked");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  ack_cause_a: assert property (wb_ack_o |-> $past(req))
    else $error("ack without request");
  dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  err_raise_a: assert property (srst |=> prot_err_o)
    else $error("no protection error");
  err_cause_a: assert property (prot_err_o |-> $past(srst))
    else $error("stray protection error");
  err_pulse_a: assert property (prot_err_o |=> !prot_err_o)
    else $error("protection error too long");
  rst_clear_a: assert property (disable iff (1'b0) rst_i |=> lut_out_o == 4'h0)
    else $error("outputs not cleared by reset");
endmodule

bind clu_top clu_asserts i_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .lut_out_o(lut_out_o),
  .prot_err_o(prot_err_o));

// ==== tb/test_clu_top.sv ====
// self-checking bench for the custom logic unit
// assumes clu_top with a classic wishbone slave
`timescale 1ns/1ps
module test_clu_top;
  reg clk_i = 0, rst_i = 1, cyc = 0, we = 0;
  reg [5:0] adr = 0;
  reg [31:0] dat = 0;
  reg [11:0] pin = 0;
  reg [4:0] tmr = 0;
  wire [31:0] rdat;
  wire ack;
  wire [3:0] lut;
  wire perr;
  int errors = 0, n_compared = 0, k, n;
  logic [63:0] q[$], x;
  clu_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .pin_in_i(pin), .timer_in_i(tmr), .lut_out_o(lut), .prot_err_o(perr));
  // clock
  initial forever #20 clk_i = ~clk_i;
  task chk(input logic [31:0] e, g);
    n_compared++;
    if (e !== g) begin
      errors++;
      $display("[FAIL] t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task conclude;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task wb(input logic w, input logic [5:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1;
    we <= w;
    adr <= a;
    dat <= d;
    @(posedge clk_i);
    while (ack !== 1'b1) @(posedge clk_i);
    cyc <= 0;
  endtask
  task rd(input logic [5:0] a, input logic [31:0] e, m);
    q.push_back({m, e & m});
    wb(0, a, 0);
  endtask
  function automatic logic [3:0] want(int k, int alt);
    want = 0;
    for (int i = 0; i < 4; i++) want[i] = (k == (alt ? i : (i + 4) % 5));
  endfunction
  // compare read data with the oldest note at each read ack
  always @(posedge clk_i) if (ack === 1'b1 && !we && q.size() > 0) begin
    x = q.pop_front();
    chk(x[31:0], rdat & x[63:32]);
  end
  // watchdog
  initial begin
    #100000;
    errors++;
    conclude;
  end
  // tests
  initial begin
    void'($urandom(32'h30B905C0));
    repeat (3) @(posedge clk_i);
    rst_i <= 0;
    pin <= 12'($urandom);
    for (n = 0; n < 4; n++) wb(1, 6'(16 + 4 * n), 32'h0000AA82);
    wb(1, 6'h00, 32'h2);
    for (n = 0; n < 2; n++) begin
      wb(1, 6'h00, n ? 32'h6 : 32'h2);
      for (k = 0; k < 5; k++) begin
        tmr <= 5'(1 << k);
        repeat (8) @(posedge clk_i);
        chk(want(k, n), lut);
      end
    end
    $display("timer map done");
    wb(1, 6'h00, 32'h0);
    wb(1, 6'h08, 32'h3);
    wb(1, 6'h00, 32'h2);
    tmr <= 5'h10;
    repeat (6) @(posedge clk_i);
    tmr <= 5'h01;
    repeat (6) @(posedge clk_i);
    chk(32'h1, {31'h0, lut[0]});
    $display("latch hold done");
    wb(1, 6'h00, 32'h0);
    wb(1, 6'h10, 32'h0);
    wb(1, 6'h10, 32'h0000AA82);
    wb(1, 6'h00, 32'h2);
    rd(6'h0C, 32'h1, 32'h3F);
    wb(1, 6'h00, 32'h2);
    rd(6'h0C, 32'h0, 32'h3F);
    $display("held release done");
    wb(1, 6'h10, 32'h0);
    rd(6'h10, 32'h0000AA82, '1);
    wb(1, 6'h00, 32'h3);
    chk(32'h1, {31'h0, perr});
    rd(6'h00, 32'h2, '1);
    rd(6'h20, 32'h0, '1);
    $display("lock and error done");
    conclude;
  end
endmodule
